// File: common/adc_cfg_pkg.sv
/*
 * Constants and types for the analog-input configuration register set:
 * word layout, register select codes, the packed configuration carrier,
 * the resolved conversion setup and the block's state record.
 * Assumes 16-bit words shifted MSB first over a 3-wire serial port.
 */
package adc_cfg_pkg;

    // serial word layout
    localparam int WORD_BITS = 16;
    localparam int CONFIG_FLAG_BIT = 15;
    localparam int CODE_HI = 15;
    localparam int CODE_LO = 11;
    localparam int FIELD_HI = 10;
    localparam int FIELD_LO = 3;
    localparam int COMMON_BIT = 2;
    localparam int NUM_PAIRS = 8;

    // register select codes in bits 15:11
    localparam logic [4:0] PAIRING_REGISTER_CODE = 5'h11;
    localparam logic [4:0] BIPOLAR_REGISTER_CODE = 5'h12;
    localparam logic [4:0] UPPER_SCAN_REGISTER_CODE = 5'h14;

    // bit counter: full word, and a saturation value past it
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_OVER = 5'h11;

    // register contents; index p of a pair vector is pair 2p/2p+1,
    // index k of the scan vector is input 8+k
    typedef struct packed {
        logic [NUM_PAIRS-1:0] pseudo_diff_pair_bit;
        logic [NUM_PAIRS-1:0] bipolar_pair_bit;
        logic [NUM_PAIRS-1:0] scan_include_bit;
        logic common_reference_bit;
    } pair_cfg_t;

    // conversion setup for the channel on channel_select_field
    typedef struct packed {
        logic differential;
        logic twos_complement;
        logic vs_negative_ref_input;
        logic scan_included;
    } conv_result_t;

    typedef struct packed {
        logic sclk_prev;
        logic cs_n_prev;
        logic [4:0] bit_cnt;
        logic [WORD_BITS-1:0] shift;
        pair_cfg_t cfg;
        conv_result_t result;
        logic data_invalid;
        logic [WORD_BITS-1:0] mode_word;
        logic mode_stb;
    } cfg_state_t;

    // select idles high; a zero here would fake a frame end after reset
    localparam cfg_state_t STATE_RESET = '{cs_n_prev: 1'b1, default: '0};

    // pair bits sit with pair 0/1 at bit 10 and pair 14/15 at bit 3
    function automatic logic [NUM_PAIRS-1:0] pair_field(
        input logic [WORD_BITS-1:0] w);
        logic [NUM_PAIRS-1:0] r;
        r = '0;
        for (int p = 0; p < NUM_PAIRS; p++) begin
            r[p] = w[FIELD_HI - p];
        end
        return r;
    endfunction

endpackage

// File: core/adc_input_config_regs.sv
/*
 * Configuration register set of a multichannel SAR converter: receives
 * 16-bit words over the 3-wire serial port, decodes the pairing, bipolar
 * and upper-scan registers, and resolves the setup of the selected channel.
 * Assumes serial pins already synchronous to clk_sys_i and a serial clock
 * well below half the system rate; shifts on the rising serial edge.
 */
`timescale 1ns/10ps
`default_nettype none

module adc_input_config_regs (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic [3:0] channel_select_field_i,
    input wire logic conversion_active_i,
    output adc_cfg_pkg::pair_cfg_t cfg_o,
    output adc_cfg_pkg::conv_result_t result_o,
    output logic data_invalid_o,
    output logic [adc_cfg_pkg::WORD_BITS-1:0] mode_word_o,
    output logic mode_stb_o
);
    import adc_cfg_pkg::*;

    cfg_state_t state_reg;
    cfg_state_t state_next;
    logic sclk_rise;
    logic frame_end;
    logic word_full;
    logic config_word;
    logic mode_word;
    logic [4:0] word_code;
    logic [NUM_PAIRS-1:0] pair_diff;
    logic [NUM_PAIRS-1:0] pair_twos;
    logic [2:0] pair_sel;
    logic [2:0] upper_sel;

    ////////////////////////////////////////////////////////////////////////
    // frame decoding

    // edges found against last cycle's pins; pins are already synchronous
    assign sclk_rise = sclk_i & ~state_reg.sclk_prev;
    assign frame_end = ~state_reg.cs_n_prev & cs_n_i;
    // short or long frames are dropped rather than half-applied
    assign word_full = (state_reg.bit_cnt == CNT_FULL);
    assign config_word = frame_end & word_full
        & state_reg.shift[CONFIG_FLAG_BIT];
    assign mode_word = frame_end & word_full
        & ~state_reg.shift[CONFIG_FLAG_BIT];
    assign word_code = state_reg.shift[CODE_HI:CODE_LO];
    assign pair_sel = channel_select_field_i[3:1];
    assign upper_sel = channel_select_field_i[2:0];

    ////////////////////////////////////////////////////////////////////////
    // per-pair resolution

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_pair
            pair_mode_resolve u_resolve (
                .pseudo_diff_i(state_reg.cfg.pseudo_diff_pair_bit[gp]),
                .bipolar_i(state_reg.cfg.bipolar_pair_bit[gp]),
                .common_ref_i(state_reg.cfg.common_reference_bit),
                .differential_o(pair_diff[gp]),
                .twos_complement_o(pair_twos[gp])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // next state

    // shifter, register decode, invalid flag and resolved setup
    always_comb begin
        state_next = state_reg;
        state_next.sclk_prev = sclk_i;
        state_next.cs_n_prev = cs_n_i;
        state_next.mode_stb = 1'b0;
        if (cs_n_i) begin
            state_next.bit_cnt = CNT_ZERO;
        end else if (sclk_rise) begin
            state_next.shift = {state_reg.shift[WORD_BITS-2:0], din_i};
            if (state_reg.bit_cnt != CNT_OVER) begin
                state_next.bit_cnt = state_reg.bit_cnt + CNT_ONE;
            end
        end
        // other config codes belong to registers outside this block
        if (config_word) begin
            case (word_code)
                PAIRING_REGISTER_CODE: begin
                    state_next.cfg.pseudo_diff_pair_bit =
                        pair_field(state_reg.shift);
                    state_next.cfg.common_reference_bit =
                        state_reg.shift[COMMON_BIT];
                end
                BIPOLAR_REGISTER_CODE: begin
                    state_next.cfg.bipolar_pair_bit =
                        pair_field(state_reg.shift);
                end
                UPPER_SCAN_REGISTER_CODE: begin
                    state_next.cfg.scan_include_bit =
                        state_reg.shift[FIELD_HI:FIELD_LO];
                end
                default: begin
                    state_next.cfg = state_reg.cfg;
                end
            endcase
        end
        // the running conversion finishes; the output stream is untrusted
        if (mode_word) begin
            state_next.data_invalid = 1'b0;
            state_next.mode_word = state_reg.shift;
            state_next.mode_stb = 1'b1;
        end
        if (config_word && conversion_active_i) begin
            state_next.data_invalid = 1'b1;
        end
        // registered so the converter sees a glitch-free setup
        state_next.result.differential = pair_diff[pair_sel];
        state_next.result.twos_complement = pair_twos[pair_sel];
        state_next.result.vs_negative_ref_input =
            state_reg.cfg.common_reference_bit;
        state_next.result.scan_included = channel_select_field_i[3]
            & state_reg.cfg.scan_include_bit[upper_sel];
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfg_o = state_reg.cfg;
    assign result_o = state_reg.result;
    assign data_invalid_o = state_reg.data_invalid;
    assign mode_word_o = state_reg.mode_word;
    assign mode_stb_o = state_reg.mode_stb;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_cfg_frame(logic [4:0] code);
        frame_end && word_full && state_reg.shift[CODE_HI:CODE_LO] == code;
    endsequence

    sequence s_mode_frame;
        frame_end && word_full && !state_reg.shift[CONFIG_FLAG_BIT];
    endsequence

    property p_pairing_write;
        s_cfg_frame(PAIRING_REGISTER_CODE) |=>
            cfg_o.pseudo_diff_pair_bit == pair_field($past(state_reg.shift))
            && cfg_o.common_reference_bit ==
               $past(state_reg.shift[COMMON_BIT]);
    endproperty
    a_pairing_write: assert property (p_pairing_write)
        else $error("pairing register not loaded from frame");

    property p_bipolar_write;
        s_cfg_frame(BIPOLAR_REGISTER_CODE) |=>
            cfg_o.bipolar_pair_bit == pair_field($past(state_reg.shift))
            && $stable(cfg_o.pseudo_diff_pair_bit);
    endproperty
    a_bipolar_write: assert property (p_bipolar_write)
        else $error("bipolar register not loaded from frame");

    property p_scan_write;
        s_cfg_frame(UPPER_SCAN_REGISTER_CODE) |=>
            cfg_o.scan_include_bit ==
            $past(state_reg.shift[FIELD_HI:FIELD_LO]);
    endproperty
    a_scan_write: assert property (p_scan_write)
        else $error("upper scan register not loaded from frame");

    property p_hold_between_frames;
        !frame_end |=> $stable(cfg_o);
    endproperty
    a_hold_between_frames: assert property (p_hold_between_frames)
        else $error("configuration changed outside a frame end");

    property p_single_ended;
        !cfg_o.common_reference_bit && !cfg_o.pseudo_diff_pair_bit[pair_sel]
        && !cfg_o.bipolar_pair_bit[pair_sel] && $stable(cfg_o)
        |=> !result_o.differential && !result_o.twos_complement;
    endproperty
    a_single_ended: assert property (p_single_ended)
        else $error("single-ended setup resolved wrongly");

    property p_bipolar_diff;
        !cfg_o.common_reference_bit && !cfg_o.pseudo_diff_pair_bit[pair_sel]
        && cfg_o.bipolar_pair_bit[pair_sel] && $stable(cfg_o)
        |=> result_o.differential && result_o.twos_complement;
    endproperty
    a_bipolar_diff: assert property (p_bipolar_diff)
        else $error("bipolar pair not two's complement differential");

    property p_pseudo_wins;
        !cfg_o.common_reference_bit && cfg_o.pseudo_diff_pair_bit[pair_sel]
        && $stable(cfg_o)
        |=> result_o.differential && !result_o.twos_complement;
    endproperty
    a_pseudo_wins: assert property (p_pseudo_wins)
        else $error("pseudo-differential pair not straight binary");

    property p_common_ref;
        cfg_o.common_reference_bit && $stable(cfg_o) |=>
            result_o.vs_negative_ref_input && !result_o.differential
            && !result_o.twos_complement;
    endproperty
    a_common_ref: assert property (p_common_ref)
        else $error("common reference mode resolved wrongly");

    property p_invalid_set;
        frame_end && word_full && state_reg.shift[CONFIG_FLAG_BIT]
        && conversion_active_i |=> data_invalid_o [*2];
    endproperty
    a_invalid_set: assert property (p_invalid_set)
        else $error("data not marked invalid after config in conversion");

    property p_invalid_clear;
        s_mode_frame |=> !data_invalid_o && mode_stb_o
            && mode_word_o == $past(state_reg.shift);
    endproperty
    a_invalid_clear: assert property (p_invalid_clear)
        else $error("mode word did not revalidate data");

    property p_invalid_holds;
        data_invalid_o && !frame_end |=> data_invalid_o;
    endproperty
    a_invalid_holds: assert property (p_invalid_holds)
        else $error("invalid flag dropped without a mode word");

endmodule // adc_input_config_regs

`default_nettype wire

// File: core/pair_mode_resolve.sv
/*
 * Resolves one input pair's conversion style from its pseudo-differential
 * bit, its bipolar bit and the global common-reference bit.
 * Assumes purely combinational use; the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none

module pair_mode_resolve (
    input wire logic pseudo_diff_i,
    input wire logic bipolar_i,
    input wire logic common_ref_i,
    output logic differential_o,
    output logic twos_complement_o
);

    // common reference overrides everything, then pseudo beats bipolar
    always_comb begin
        differential_o = 1'b0;
        twos_complement_o = 1'b0;
        if (common_ref_i) begin
            differential_o = 1'b0;
        end else if (pseudo_diff_i) begin
            differential_o = 1'b1;
        end else if (bipolar_i) begin
            differential_o = 1'b1;
            twos_complement_o = 1'b1;
        end else begin
            differential_o = 1'b0;
        end
    end

endmodule // pair_mode_resolve

`default_nettype wire

// File: tb/host_master.sv
/*
 * Host-side serial master model: frames words onto sclk, cs_n and din.
 * Assumes clk_sys_i from the bench; pins move 1 ns after rising edges.
 */
`timescale 1ns/10ps
`default_nettype none

module host_master (
    input wire logic clk_sys_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    // serial clock idles low, select idles high
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame of n bits; slow stretches each serial phase
    task automatic send(input logic [31:0] w, input int n, input int slow);
        @(posedge clk_sys_i);
        #1 cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            repeat (slow + 1) @(posedge clk_sys_i);
            #1 sclk_o = 1'b0;
            din_o = w[i];
            repeat (slow + 1) @(posedge clk_sys_i);
            #1 sclk_o = 1'b1;
        end
        repeat (slow + 1) @(posedge clk_sys_i);
        #1 sclk_o = 1'b0;
        @(posedge clk_sys_i);
        #1 cs_n_o = 1'b1;
        din_o = ~din_o; // released line must not keep a stale bit
    endtask
endmodule // host_master

`default_nettype wire

// File: tb/tb.sv
/*
 * Self-checking bench of the configuration register set: directed and
 * random frames from the host model; a watcher checks queued notes.
 * Assumes host_master drives the serial pins.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
    import adc_cfg_pkg::*;
    typedef struct packed {
        pair_cfg_t cfg;
        logic inv;
        logic stb;
        logic [15:0] mw;
        conv_result_t res;
    } note_t;
    logic clk_sys_i, reset_n_i, sclk, cs_n, din, conv_act;
    logic [3:0] chan;
    pair_cfg_t cfg_o;
    conv_result_t result_o;
    logic data_invalid_o, mode_stb_o;
    logic [15:0] mode_word_o;
    note_t q[$];
    note_t m;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h8e98;
    logic [4:0] codes [5] = '{5'h11, 5'h12, 5'h14, 5'h13, 5'h0a};
    logic [31:0] dir [10] = '{32'h8ff8, 32'h97f8, 32'h8800, 32'h9000,
        32'ha7f8, 32'h8804, 32'h47fc, 32'h11ff0, 32'h0123, 32'h8800};
    int len [10] = '{16, 16, 16, 16, 16, 16, 15, 17, 16, 16};

    adc_input_config_regs i_dut (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .channel_select_field_i(chan), .conversion_active_i(conv_act),
        .cfg_o(cfg_o), .result_o(result_o), .data_invalid_o(data_invalid_o),
        .mode_word_o(mode_word_o), .mode_stb_o(mode_stb_o));
    host_master i_host (.clk_sys_i(clk_sys_i), .sclk_o(sclk),
        .cs_n_o(cs_n), .din_o(din));

    ////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // pair index is channel / 2; scan only covers inputs 8..15
    function automatic conv_result_t resolve(pair_cfg_t c, logic [3:0] ch);
        conv_result_t r;
        r = '0;
        if (c.common_reference_bit) begin
            r.vs_negative_ref_input = 1'b1;
        end else if (c.pseudo_diff_pair_bit[ch[3:1]]) begin
            r.differential = 1'b1;
        end else if (c.bipolar_pair_bit[ch[3:1]]) begin
            r.differential = 1'b1;
            r.twos_complement = 1'b1;
        end
        r.scan_included = ch[3] & c.scan_include_bit[ch[2:0]];
        return r;
    endfunction

    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (e !== g) begin
            err_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // note the expected outcome, then have the host send the frame
    task automatic frame(input logic [31:0] w, input int n, input int slow);
        logic [15:0] v;
        v = w[15:0];
        repeat (3) @(posedge clk_sys_i);
        rng = xs(rng);
        #1 chan = rng[23:20];
        conv_act = rng[24];
        m.stb = 1'b0;
        if (n == 16 && !v[15]) begin
            m.inv = 1'b0;
            m.stb = 1'b1;
            m.mw = v;
        end else if (n == 16) begin
            m.inv = m.inv | conv_act;
            case (v[15:11])
                5'h11: begin
                    m.cfg.pseudo_diff_pair_bit = {<<{v[10:3]}};
                    m.cfg.common_reference_bit = v[2];
                end
                5'h12: m.cfg.bipolar_pair_bit = {<<{v[10:3]}};
                5'h14: m.cfg.scan_include_bit = v[10:3];
                default: ;
            endcase
        end
        m.res = resolve(m.cfg, chan);
        q.push_back(m);
        i_host.send(w, n, slow);
    endtask

    // watcher: registers and the one-cycle strobe show after the first
    // edge past the select rise; the resolved setup one edge later
    initial begin
        note_t e;
        wait (reset_n_i === 1'b1);
        forever begin
            @(posedge cs_n);
            @(posedge clk_sys_i);
            #2 e = q.pop_front();
            cmp(e.cfg, cfg_o);
            cmp(e.inv, data_invalid_o);
            cmp({e.stb, e.mw}, {mode_stb_o, mode_word_o});
            @(posedge clk_sys_i);
            #2 cmp(e.res, result_o);
        end
    end

    // hang guard
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset, directed frames (each register code, mode words, bad lengths), then random ones
    initial begin
        reset_n_i = 1'b0;
        conv_act = 1'b0;
        chan = 4'h0;
        m = '0;
        repeat (6) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        @(posedge clk_sys_i);
        #2 cmp(32'h0, cfg_o);
        cmp(32'h0, {data_invalid_o, mode_stb_o, mode_word_o, result_o});
        foreach (dir[i]) frame(dir[i], len[i], 0);
        repeat (60) begin
            rng = xs(rng);
            frame({16'h0, codes[rng[27:25] % 5], rng[10:0]}, 16, rng[17:16]);
        end
        repeat (8) @(posedge clk_sys_i);
        give_verdict();
    end
endmodule // tb

`default_nettype wire
